//--- dv/cam_sensor_model.sv
// Behavioural image sensor driving one port
`timescale 1ns/1ps
module cam_sensor_model (
   // Sensor pins
   output logic o_sensor_pixel_clock,
   output logic o_sensor_frame_sync,
   output logic o_sensor_line_sync,
   output logic [19:0] o_sensor_pixel_bus
);
   logic inv_vs;
   logic inv_hs;
   logic inv_pc;
   logic vs_lvl;
   logic hs_lvl;
   logic pc_lvl;
   initial begin
      inv_vs = 1'b0;
      inv_hs = 1'b0;
      inv_pc = 1'b0;
      vs_lvl = 1'b0;
      hs_lvl = 1'b0;
      pc_lvl = 1'b0;
      o_sensor_pixel_bus = 20'h00000;
   end
   assign o_sensor_pixel_clock = pc_lvl ^ inv_pc;
   assign o_sensor_frame_sync = vs_lvl ^ inv_vs;
   assign o_sensor_line_sync = hs_lvl ^ inv_hs;
   task automatic set_pol(input logic p);
      #10;
      inv_vs = p;
      inv_hs = p;
      inv_pc = p;
   endtask : set_pol
   task automatic frame(input logic on);
      #110 vs_lvl = on;
      #90;
   endtask : frame
   task automatic line(input logic on);
      #110 hs_lvl = on;
      #90;
   endtask : line
   task automatic send(input logic [19:0] w);
      #13 o_sensor_pixel_bus = w;
      #197 pc_lvl = 1'b1;
      #180 pc_lvl = 1'b0;
      o_sensor_pixel_bus = ~w;
      #10;
   endtask : send
endmodule : cam_sensor_model

//--- dv/camera_sensor_input_port_checker.sv
// Pin-level assertions for the camera input port
`timescale 1ns/1ps
module camera_port_checker (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // APB
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pslverr,
   // Sensor and stream
   input wire logic [1:0] i_sensor_pixel_clock,
   input wire logic [1:0] o_pix_valid,
   input wire logic [1:0][29:0] o_pix_data,
   input wire logic [1:0] o_frame_sync,
   input wire logic [1:0] o_line_sync
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ****
   // Relations
   // ****
   slverr_phase_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("slave error outside access");
   unmapped_err_a: assert property (i_psel && i_penable && i_paddr[11:4] != 8'h00 |-> o_pslverr)
      else $error("no slave error on unmapped address");
   pulse_once_a: assert property ((o_pix_valid & $past(o_pix_valid)) == 2'h0)
      else $error("pixel valid longer than one cycle");
   edge_port0_a: assert property (o_pix_valid[0] |->
      $past(i_sensor_pixel_clock[0], 3) != $past(i_sensor_pixel_clock[0], 4))
      else $error("port 0 pixel without clock edge");
   edge_port1_a: assert property (o_pix_valid[1] |->
      $past(i_sensor_pixel_clock[1], 3) != $past(i_sensor_pixel_clock[1], 4))
      else $error("port 1 pixel without clock edge");
   line_gate_a: assert property ((o_pix_valid & ~o_line_sync) == 2'h0)
      else $error("pixel outside active line");
   frame_gate_a: assert property ((o_pix_valid & ~o_frame_sync) == 2'h0)
      else $error("pixel outside frame");
   data_hold_a: assert property (!o_pix_valid[0] |-> $stable(o_pix_data[0]))
      else $error("pixel data moved without valid");
   data_hold1_a: assert property (!o_pix_valid[1] |-> $stable(o_pix_data[1]))
      else $error("port 1 pixel data moved without valid");
endmodule : camera_port_checker

bind camera_sensor_input_port camera_port_checker chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable), .o_pslverr(o_pslverr),
   .i_sensor_pixel_clock(i_sensor_pixel_clock), .o_pix_valid(o_pix_valid), .o_pix_data(o_pix_data),
   .o_frame_sync(o_frame_sync), .o_line_sync(o_line_sync));

//--- dv/test_camera_sensor_input_port.sv
// Self-checking bench of the camera input port
`timescale 1ns/1ps
module test_camera_sensor_input_port;
   logic clk;
   logic rst_n;
   logic [11:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   wire logic [1:0] pclk;
   wire logic [1:0] vs;
   wire logic [1:0] hs;
   wire logic [1:0][19:0] bus;
   logic [1:0] pvalid;
   logic [1:0][29:0] pdata;
   logic [1:0] fsync;
   logic [1:0] lsync;
   logic [29:0] q0 [$];
   logic [29:0] q1 [$];
   int err_total;
   int samples_checked;
   logic [31:0] rd;
   logic er;
   logic [31:0] ictl [6] = '{32'h2D, 32'h23, 32'h43, 32'h29, 32'h21, 32'h2B};
   logic [31:0] gctl [4] = '{32'h2B, 32'h33, 32'h4B, 32'h3AB};
   logic [31:0] nctl [4] = '{32'h0F, 32'h17, 32'h1F, 32'h07};
   logic [29:0] nexp [4] = '{30'h00B54DF7, 30'h00B24DF3, 30'h00B34EF1, 30'h004AD79C};
   logic [31:0] ectl [3] = '{32'h21, 32'h41, 32'h39};
   logic [19:0] ea [3] = '{20'h11ABC, 20'hAB3D8, 20'hAB7DB};
   logic [19:0] eb [3] = '{20'hE2555, 20'h5C3F4, 20'h5CFF7};
   logic [29:0] xa [3] = '{30'h00000011, 30'h000AB3D8, 30'h000AB3D8};
   logic [29:0] xb [3] = '{30'h000000E2, 30'h0005C3F4, 30'h0005C3F4};
   cam_sensor_model m0 (.o_sensor_pixel_clock(pclk[0]), .o_sensor_frame_sync(vs[0]),
      .o_sensor_line_sync(hs[0]), .o_sensor_pixel_bus(bus[0]));
   cam_sensor_model m1 (.o_sensor_pixel_clock(pclk[1]), .o_sensor_frame_sync(vs[1]),
      .o_sensor_line_sync(hs[1]), .o_sensor_pixel_bus(bus[1]));
   camera_sensor_input_port dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_paddr(paddr), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_sensor_pixel_clock(pclk), .i_sensor_frame_sync(vs), .i_sensor_line_sync(hs),
      .i_sensor_pixel_bus(bus), .o_pix_valid(pvalid), .o_pix_data(pdata), .o_frame_sync(fsync),
      .o_line_sync(lsync));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (pvalid[0] === 1'b1) q0.push_back(pdata[0]);
      if (pvalid[1] === 1'b1) q1.push_back(pdata[1]);
   end
   // ****
   // Tasks
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic take(input int p, input logic [29:0] exp);
      logic [29:0] v;
      v = 'x;
      if (p == 0 && q0.size() > 0) v = q0.pop_front();
      if (p == 1 && q1.size() > 0) v = q1.pop_front();
      check({2'h0, v}, {2'h0, exp});
   endtask : take
   task automatic emb_line(input logic [19:0] a, input logic [19:0] b);
      logic [7:0] hdr [10] = '{8'h10, 8'hFF, 8'h00, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h10};
      for (int k = 0; k < 10; k++) begin
         m0.send({hdr[k], 12'h000});
         if (k == 4) begin
            m0.send(a);
            m0.send(b);
         end
      end
   endtask : emb_line
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #2000000;
      err_total++;
      tally_and_finish();
   end
   // ****
   // Tests
   // ****
   initial begin
      err_total = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h00000000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h000003FF);
      apb(1'b0, 12'h010, 32'h0);
      check({31'h0, er}, 32'h00000001);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h004, ictl[i]);
         apb(1'b0, 12'h00C, 32'h0);
         check({31'h0, rd[0]}, {31'h0, i < 4});
      end
      $display("test registers finished");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h000, 32'h0);
         m0.set_pol(i == 3);
         apb(1'b1, 12'h000, gctl[i]);
         m0.frame(1'b1);
         m0.line(1'b1);
         m0.send(20'h5A6C3);
         m0.send(20'hA593C);
         m0.line(1'b0);
         m0.send(20'h12345);
         m0.frame(1'b0);
         repeat (12) @(posedge clk);
         take(0, (i == 1 || i == 2) ? 30'h0005A6C3 : 30'h005A4D63);
         take(0, (i == 1 || i == 2) ? 30'h000A593C : 30'h00A5B29C);
         check(q0.size(), 32'h0);
      end
      apb(1'b1, 12'h000, 32'h0);
      m0.set_pol(1'b0);
      $display("test gated finished");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h004, nctl[i]);
         m1.frame(1'b1);
         // Line sync toggled, must be ignored
         m1.line(i[0]);
         m1.send({8'hB3, 12'hC3A});
         m1.send({8'h4E, 12'h5A5});
         m1.send({8'hF1, 12'h0F0});
         m1.frame(1'b0);
         repeat (12) @(posedge clk);
         take(1, nexp[i]);
         check(q1.size() + q0.size(), 32'h0);
      end
      $display("test nongated finished");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'h000, ectl[i]);
         emb_line(ea[i], eb[i]);
         repeat (12) @(posedge clk);
         take(0, xa[i]);
         take(0, xb[i]);
         check(q0.size(), 32'h0);
      end
      $display("test embedded finished");
      tally_and_finish();
   end
endmodule : test_camera_sensor_input_port

//--- rtl/cam_port_map.svh
// Register offsets, field positions, reset values and codes of the camera input port
`ifndef CAM_PORT_MAP_SVH
`define CAM_PORT_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define CAM_NUM_PORTS 2
`define CAM_BUS_W 20
`define CAM_OUT_W 30
`define CAM_CTRL_W 10

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CAM_OFS_CTRL0 12'h000
`define CAM_OFS_CTRL1 12'h004
`define CAM_OFS_STAT0 12'h008
`define CAM_OFS_STAT1 12'h00C

// ****************************************************************
// Control fields
// ****************************************************************
`define CAM_CTRL_RST 10'h000
`define CAM_CTRL_EN_BIT 0
`define CAM_CTRL_MODE_LSB 1
`define CAM_CTRL_MODE_MSB 2
`define CAM_CTRL_FMT_LSB 3
`define CAM_CTRL_FMT_MSB 6
`define CAM_CTRL_VS_FALL_BIT 7
`define CAM_CTRL_HS_LOW_BIT 8
`define CAM_CTRL_PCLK_FALL_BIT 9

// ****************************************************************
// Status fields
// ****************************************************************
`define CAM_STAT_ILLEGAL_BIT 0
`define CAM_STAT_FRAME_BIT 1
`define CAM_STAT_LINE_BIT 2
`define CAM_STAT_LCNT_LSB 4
`define CAM_STAT_LCNT_MSB 15
`define CAM_STAT_FCNT_LSB 16
`define CAM_STAT_FCNT_MSB 31

// ****************************************************************
// Embedded timing codes
// ****************************************************************
`define CAM_CODE_FF 8'hFF
`define CAM_CODE_00 8'h00
`define CAM_XY_V_BIT 5
`define CAM_XY_H_BIT 4

`endif

//--- rtl/cam_port_pkg.sv
// Types of the camera sensor input port
package cam_port_pkg;
`include "cam_port_map.svh"

   typedef enum logic [1:0] {
      MODE_EMBEDDED = 2'h0,
      MODE_GATED = 2'h1,
      MODE_NONGATED = 2'h3
   } mode_e;

   typedef enum logic [3:0] {
      FMT_RGB565_2C = 4'h0,
      FMT_RGB565_3C = 4'h1,
      FMT_RGB666_3C = 4'h2,
      FMT_RGB888_3C = 4'h3,
      FMT_YUV8 = 4'h4,
      FMT_RGB565_16 = 4'h5,
      FMT_YUV16_RAW = 4'h6,
      FMT_YUV16_SUB = 4'h7,
      FMT_YUV20 = 4'h8,
      FMT_GENERIC = 4'h9
   } fmt_e;

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_d;
      logic vs_s1;
      logic vs_s2;
      logic vs_d;
      logic hs_s1;
      logic hs_s2;
      logic [`CAM_BUS_W-1:0] bus_s1;
      logic [`CAM_BUS_W-1:0] bus_s2;
      logic [1:0] pre_cnt;
      logic frame_on;
      logic line_on;
      logic [1:0] phase;
      logic [7:0] hold_a;
      logic [7:0] hold_b;
      logic pix_valid;
      logic [`CAM_OUT_W-1:0] pix_data;
      logic [15:0] frame_cnt;
      logic [11:0] line_cnt;
   } chan_s;

   typedef struct packed {
      chan_s [`CAM_NUM_PORTS-1:0] ch;
      logic [`CAM_NUM_PORTS-1:0][`CAM_CTRL_W-1:0] ctrl;
      logic [31:0] prdata;
   } state_s;

endpackage : cam_port_pkg

//--- rtl/camera_sensor_input_port.sv
// Dual camera sensor input port with APB control
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module camera_sensor_input_port (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // APB slave
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Sensor pins, one lane per port
   input wire logic [`CAM_NUM_PORTS-1:0] i_sensor_pixel_clock,
   input wire logic [`CAM_NUM_PORTS-1:0] i_sensor_frame_sync,
   input wire logic [`CAM_NUM_PORTS-1:0] i_sensor_line_sync,
   input wire logic [`CAM_NUM_PORTS-1:0][`CAM_BUS_W-1:0] i_sensor_pixel_bus,
   // Pixel stream out, one lane per port
   output logic [`CAM_NUM_PORTS-1:0] o_pix_valid,
   output logic [`CAM_NUM_PORTS-1:0][`CAM_OUT_W-1:0] o_pix_data,
   output logic [`CAM_NUM_PORTS-1:0] o_frame_sync,
   output logic [`CAM_NUM_PORTS-1:0] o_line_sync
);

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   // Widen 5-bit colour
   function automatic logic [7:0] ext5(input logic [4:0] x);
      ext5 = {x, x[4:2]};
   endfunction : ext5

   // Widen 6-bit colour
   function automatic logic [7:0] ext6(input logic [5:0] x);
      ext6 = {x, x[5:4]};
   endfunction : ext6

   // Mode and format pairing
   function automatic logic legal_cfg(input logic [1:0] m, input logic [3:0] f);
      logic emb_fmt;
      emb_fmt = (f == cam_port_pkg::FMT_YUV8) || (f == cam_port_pkg::FMT_YUV16_SUB) ||
                (f == cam_port_pkg::FMT_YUV20);
      legal_cfg = 1'b0;
      if (m == cam_port_pkg::MODE_EMBEDDED) begin
         legal_cfg = emb_fmt;
      end
      else if (m == cam_port_pkg::MODE_GATED || m == cam_port_pkg::MODE_NONGATED) begin
         legal_cfg = !emb_fmt && (f <= cam_port_pkg::FMT_GENERIC);
      end
   endfunction : legal_cfg

   // Last word index of a pixel
   function automatic logic [1:0] last_phase(input logic [3:0] f);
      if (f == cam_port_pkg::FMT_RGB565_2C) begin
         last_phase = 2'h1;
      end
      else if (f == cam_port_pkg::FMT_RGB565_3C || f == cam_port_pkg::FMT_RGB666_3C ||
               f == cam_port_pkg::FMT_RGB888_3C) begin
         last_phase = 2'h2;
      end
      else begin
         last_phase = 2'h0;
      end
   endfunction : last_phase

   // Build one output pixel
   function automatic logic [`CAM_OUT_W-1:0] assemble(input logic [3:0] f, input logic [7:0] a,
                                                      input logic [7:0] b, input logic [`CAM_BUS_W-1:0] w);
      logic [7:0] c;
      c = w[19:12];
      unique case (f)
         cam_port_pkg::FMT_RGB565_2C: begin
            assemble = {6'h00, ext5(c[7:3]), ext6({c[2:0], a[7:5]}), ext5(a[4:0])};
         end
         cam_port_pkg::FMT_RGB565_3C: begin
            assemble = {6'h00, ext5(a[7:3]), ext6(b[7:2]), ext5(c[7:3])};
         end
         cam_port_pkg::FMT_RGB666_3C: begin
            assemble = {6'h00, ext6(a[7:2]), ext6(b[7:2]), ext6(c[7:2])};
         end
         cam_port_pkg::FMT_RGB888_3C: begin
            assemble = {6'h00, a, b, c};
         end
         cam_port_pkg::FMT_YUV8: begin
            assemble = {22'h000000, c};
         end
         cam_port_pkg::FMT_RGB565_16: begin
            assemble = {6'h00, ext5(w[19:15]), ext6(w[14:9]), ext5(w[8:4])};
         end
         cam_port_pkg::FMT_YUV16_SUB: begin
            assemble = {10'h000, w[19:12], 2'h0, w[9:2], 2'h0};
         end
         cam_port_pkg::FMT_YUV20: begin
            assemble = {10'h000, w};
         end
         default: begin
            assemble = {10'h000, w};
         end
      endcase
   endfunction : assemble

   // ****************************************************************
   // State
   // ****************************************************************
   cam_port_pkg::state_s st_ff;
   cam_port_pkg::state_s nxt_st;

   logic apb_access;
   logic apb_mapped;

   assign apb_access = i_psel & i_penable;
   assign apb_mapped = (i_paddr == `CAM_OFS_CTRL0) || (i_paddr == `CAM_OFS_CTRL1) ||
                       (i_paddr == `CAM_OFS_STAT0) || (i_paddr == `CAM_OFS_STAT1);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [`CAM_CTRL_W-1:0] ctl;
      logic [1:0] mode;
      logic [3:0] fmt;
      logic en;
      logic clk_rise;
      logic clk_fall;
      logic pclk_edge;
      logic vs_adj;
      logic hs_adj;
      logic frame_start;
      logic push;
      logic [`CAM_BUS_W-1:0] word;
      logic [7:0] w8;
      ctl = '0;
      mode = 2'h0;
      fmt = 4'h0;
      en = 1'b0;
      clk_rise = 1'b0;
      clk_fall = 1'b0;
      pclk_edge = 1'b0;
      vs_adj = 1'b0;
      hs_adj = 1'b0;
      frame_start = 1'b0;
      push = 1'b0;
      word = '0;
      w8 = 8'h00;
      nxt_st = st_ff;

      // Register writes
      if (apb_access && i_pwrite) begin
         if (i_paddr == `CAM_OFS_CTRL0) begin
            nxt_st.ctrl[0] = i_pwdata[`CAM_CTRL_W-1:0];
         end
         if (i_paddr == `CAM_OFS_CTRL1) begin
            nxt_st.ctrl[1] = i_pwdata[`CAM_CTRL_W-1:0];
         end
      end

      for (int p = 0; p < `CAM_NUM_PORTS; p++) begin
         ctl = st_ff.ctrl[p];
         mode = ctl[`CAM_CTRL_MODE_MSB:`CAM_CTRL_MODE_LSB];
         fmt = ctl[`CAM_CTRL_FMT_MSB:`CAM_CTRL_FMT_LSB];
         en = ctl[`CAM_CTRL_EN_BIT] & legal_cfg(mode, fmt);

         // Pin synchronisers
         nxt_st.ch[p].clk_s1 = i_sensor_pixel_clock[p];
         nxt_st.ch[p].clk_s2 = st_ff.ch[p].clk_s1;
         nxt_st.ch[p].clk_d = st_ff.ch[p].clk_s2;
         nxt_st.ch[p].vs_s1 = i_sensor_frame_sync[p];
         nxt_st.ch[p].vs_s2 = st_ff.ch[p].vs_s1;
         nxt_st.ch[p].hs_s1 = i_sensor_line_sync[p];
         nxt_st.ch[p].hs_s2 = st_ff.ch[p].hs_s1;
         nxt_st.ch[p].bus_s1 = i_sensor_pixel_bus[p];
         nxt_st.ch[p].bus_s2 = st_ff.ch[p].bus_s1;
         nxt_st.ch[p].pix_valid = 1'b0;

         clk_rise = st_ff.ch[p].clk_s2 & ~st_ff.ch[p].clk_d;
         clk_fall = ~st_ff.ch[p].clk_s2 & st_ff.ch[p].clk_d;
         pclk_edge = ctl[`CAM_CTRL_PCLK_FALL_BIT] ? clk_fall : clk_rise;
         vs_adj = st_ff.ch[p].vs_s2 ^ ctl[`CAM_CTRL_VS_FALL_BIT];
         hs_adj = st_ff.ch[p].hs_s2 ^ ctl[`CAM_CTRL_HS_LOW_BIT];
         nxt_st.ch[p].vs_d = vs_adj;
         frame_start = vs_adj & ~st_ff.ch[p].vs_d;
         word = st_ff.ch[p].bus_s2;
         w8 = word[19:12];

         if (!en) begin
            nxt_st.ch[p].phase = 2'h0;
            nxt_st.ch[p].pre_cnt = 2'h0;
            nxt_st.ch[p].frame_on = 1'b0;
            nxt_st.ch[p].line_on = 1'b0;
         end
         // pixel clock is the only control
         else if (mode == cam_port_pkg::MODE_EMBEDDED) begin
            if (pclk_edge) begin
               if (st_ff.ch[p].pre_cnt == 2'h3) begin
                  nxt_st.ch[p].pre_cnt = 2'h0;
                  nxt_st.ch[p].phase = 2'h0;
                  nxt_st.ch[p].frame_on = ~w8[`CAM_XY_V_BIT];
                  // start code opens, end code closes
                  nxt_st.ch[p].line_on = ~w8[`CAM_XY_V_BIT] & ~w8[`CAM_XY_H_BIT];
                  if (!w8[`CAM_XY_V_BIT] && !st_ff.ch[p].frame_on) begin
                     nxt_st.ch[p].frame_cnt = st_ff.ch[p].frame_cnt + 16'h0001;
                     nxt_st.ch[p].line_cnt = 12'h000;
                  end
                  if (!w8[`CAM_XY_V_BIT] && !w8[`CAM_XY_H_BIT]) begin
                     nxt_st.ch[p].line_cnt = nxt_st.ch[p].line_cnt + 12'h001;
                  end
               end
               else if (w8 == `CAM_CODE_FF) begin
                  nxt_st.ch[p].pre_cnt = 2'h1;
               end
               else if (st_ff.ch[p].pre_cnt != 2'h0 && w8 == `CAM_CODE_00) begin
                  nxt_st.ch[p].pre_cnt = st_ff.ch[p].pre_cnt + 2'h1;
               end
               else begin
                  nxt_st.ch[p].pre_cnt = 2'h0;
                  push = st_ff.ch[p].line_on;
               end
            end
         end
         else begin
            if (frame_start) begin
               nxt_st.ch[p].frame_cnt = st_ff.ch[p].frame_cnt + 16'h0001;
               nxt_st.ch[p].line_cnt = 12'h000;
               nxt_st.ch[p].phase = 2'h0;
            end
            nxt_st.ch[p].frame_on = vs_adj;
            if (mode == cam_port_pkg::MODE_GATED) begin
               nxt_st.ch[p].line_on = hs_adj;
               if (hs_adj && !st_ff.ch[p].line_on) begin
                  nxt_st.ch[p].line_cnt = nxt_st.ch[p].line_cnt + 12'h001;
               end
               if (!hs_adj) begin
                  nxt_st.ch[p].phase = 2'h0;
               end
               push = pclk_edge & hs_adj;
            end
            else begin
               nxt_st.ch[p].line_on = 1'b1;
               push = pclk_edge;
            end
         end

         // Pixel assembly
         if (push) begin
            if (st_ff.ch[p].phase < last_phase(fmt)) begin
               if (st_ff.ch[p].phase == 2'h0) begin
                  nxt_st.ch[p].hold_a = w8;
               end
               else begin
                  nxt_st.ch[p].hold_b = w8;
               end
               nxt_st.ch[p].phase = st_ff.ch[p].phase + 2'h1;
            end
            else begin
               nxt_st.ch[p].phase = 2'h0;
               nxt_st.ch[p].pix_valid = 1'b1;
               nxt_st.ch[p].pix_data = assemble(fmt, st_ff.ch[p].hold_a, st_ff.ch[p].hold_b, word);
            end
         end
      end

      // Read data captured in setup phase
      if (i_psel && !i_penable) begin
         unique case (i_paddr)
            `CAM_OFS_CTRL0: nxt_st.prdata = {22'h000000, st_ff.ctrl[0]};
            `CAM_OFS_CTRL1: nxt_st.prdata = {22'h000000, st_ff.ctrl[1]};
            `CAM_OFS_STAT0: nxt_st.prdata = {st_ff.ch[0].frame_cnt, st_ff.ch[0].line_cnt, 1'b0,
                                             st_ff.ch[0].line_on, st_ff.ch[0].frame_on,
                                             ~legal_cfg(st_ff.ctrl[0][`CAM_CTRL_MODE_MSB:`CAM_CTRL_MODE_LSB],
                                                        st_ff.ctrl[0][`CAM_CTRL_FMT_MSB:`CAM_CTRL_FMT_LSB])};
            `CAM_OFS_STAT1: nxt_st.prdata = {st_ff.ch[1].frame_cnt, st_ff.ch[1].line_cnt, 1'b0,
                                             st_ff.ch[1].line_on, st_ff.ch[1].frame_on,
                                             ~legal_cfg(st_ff.ctrl[1][`CAM_CTRL_MODE_MSB:`CAM_CTRL_MODE_LSB],
                                                        st_ff.ctrl[1][`CAM_CTRL_FMT_MSB:`CAM_CTRL_FMT_LSB])};
            default: nxt_st.prdata = 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_ff <= '0;
         st_ff.ctrl <= {`CAM_NUM_PORTS{`CAM_CTRL_RST}};
      end
      else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_prdata = st_ff.prdata;
   assign o_pready = 1'b1;
   assign o_pslverr = apb_access & ~apb_mapped;

   // pixel clock only, no master clock out
   for (genvar g = 0; g < `CAM_NUM_PORTS; g++) begin : g_out
      assign o_pix_valid[g] = st_ff.ch[g].pix_valid;
      assign o_pix_data[g] = st_ff.ch[g].pix_data;
      assign o_frame_sync[g] = st_ff.ch[g].frame_on;
      assign o_line_sync[g] = st_ff.ch[g].line_on;
   end

endmodule : camera_sensor_input_port
